// ---- design/sstu_map.vh ----
`ifndef SSTU_MAP_VH
`define SSTU_MAP_VH

// register byte offsets on the wishbone bus
`define SSTU_TBUF_ADDR    16'hF480
`define SSTU_RBUF_ADDR    16'hF482
`define SSTU_BAUD_ADDR    16'hF484
`define SSTU_CON1_ADDR    16'hF486
`define SSTU_CON2_ADDR    16'hF488
`define SSTU_CTR_ADDR     16'hF48A
`define SSTU_PRS_ADDR     16'hF804
`define SSTU_PIN_FUNCTION_SELECT_ADDR  16'hF826
`define SSTU_SERIAL_CLOCK_SOURCE_CONFIG_ADDR  16'hF836

// control 1 field positions
`define SSTU_C1_TUE       7
`define SSTU_C1_TX_BUFFER_EMPTY_FLAG      6
`define SSTU_C1_TIE       5
`define SSTU_C1_TEN       4
`define SSTU_C1_ROE       3
`define SSTU_C1_RX_BUFFER_FULL_FLAG      2
`define SSTU_C1_RIE       1
`define SSTU_C1_REN       0

// control 2 field positions
`define SSTU_C2_AUTO      2
`define SSTU_C2_TX_MASTER_SELECT      1
`define SSTU_C2_RX_MASTER_SELECT      0

// baud control field positions
`define SSTU_BAUD_EN      7
`define SSTU_BAUD_BV_HI   6

// source select bit of the clock source register
`define SSTU_SERIAL_CLOCK_SOURCE_CONFIG_SRC   2

// reset values
`define SSTU_CON1_RST     8'h40
`define SSTU_CON2_RST     8'h00
`define SSTU_BAUD_RST     8'h00
`define SSTU_PIN_FUNCTION_SELECT_RST   8'h00
`define SSTU_SERIAL_CLOCK_SOURCE_CONFIG_RST   8'h00
`define SSTU_PRS_RST      9'h000

// word length
`define SSTU_WORD_BITS    16
`define SSTU_BIT_CNT_LAST 4'hF

`endif

// ---- design/sstu_baud_gen.v ----
`timescale 1ns/1ns
`default_nettype none

`include "sstu_map.vh"

// baud generator: optional prescale, then seven-bit reload down counter
module sstu_baud_gen (
	input  wire       ref_clk_in,
	input  wire       srst_in,
	input  wire       enable_in,
	input  wire [6:0] reload_in,
	input  wire       reload_load_in,
	input  wire       src_serclk_in,
	input  wire [8:0] prescale_in,
	output reg  [6:0] count_out,
	output reg        baud_out,
	output reg        rise_out,
	output reg        fall_out
);

	reg  [9:0] pre_reg;
	reg        half_reg;
	wire       ser_tick;
	wire       ps_tick;
	wire       bclk_tick;

	// serial clock source is the core clock over four; prescaled is 2*(ps+2) times slower than the core clock
	assign ser_tick  = ~half_reg & pre_reg[0];
	assign ps_tick   = (pre_reg == ({1'b0, prescale_in} + 10'h001));
	assign bclk_tick = src_serclk_in ? ser_tick : ps_tick;

	always @(posedge ref_clk_in) begin
		rise_out <= 1'b0;
		fall_out <= 1'b0;
		if (srst_in) begin
			pre_reg   <= 10'h000;
			half_reg  <= 1'b0;
			count_out <= 7'h00;
			baud_out  <= 1'b0;
		end else if (!enable_in) begin
			pre_reg   <= 10'h000;
			half_reg  <= 1'b0;
			count_out <= reload_in;
			baud_out  <= 1'b0;
		end else begin
			half_reg <= ~half_reg;
			if (!half_reg) begin
				if (bclk_tick || src_serclk_in)
					pre_reg <= src_serclk_in ? (pre_reg ^ 10'h001) : 10'h000;
				else
					pre_reg <= pre_reg + 10'h001;
			end
			if (reload_load_in) begin
				count_out <= reload_in;
			end else if (!half_reg && bclk_tick) begin
				if (count_out == 7'h00) begin
					count_out <= reload_in; // (R22)
					baud_out  <= ~baud_out; // (R22)
					rise_out  <= ~baud_out;
					fall_out  <= baud_out;
				end else begin
					count_out <= count_out - 7'h01; // (R22)
				end
			end
		end
	end

endmodule

`default_nettype wire

// ---- design/sstu_unit.v ----
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

`include "sstu_map.vh"

// Overview of operation
// (R1) tx buffer loads shifter on enable, msb first
// (R2) tx clock: baud generator or external pin
// (R3) software starts generator; external clock after enable
// (R4) tx empty flag: reset set, write clears
// (R5) enabled tx reloads buffer after each word
// (R6) missed refill resends old word, sets underrun
// (R7) tx empty signal for interrupt and dma
// (R8) tx disable finishes word, floats data/clock
// (R9) quick re-enable continues as if undisturbed
// (R10) single word: enable then disable early
// (R11) autotransmit ignores enable, stops when empty
// (R12) autotransmit never sets underrun
// (R13) slave tx holds bit15 until second fall
// (R14) rx shifts msb first, 16 bits to buffer
// (R15) rx full flag: set on load, read clears
// (R16) unread word overwritten, overflow flag set
// (R17) rx full signal; irq combines both sources
// (R18) rx disable finishes word, floats master clock
// (R19) quick rx re-enable continues undisturbed
// (R20) slave rx samples on next rising edge
// (R21) single rx word: enable then disable early
// (R22) seven-bit reload down counter baud generator
// (R23) separate tx/rx master select bits
// (R24) external clocks synchronised before edge detect
module sstu_unit (
	input  wire        ref_clk_in,
	input  wire        srst_in,
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [15:0] wb_adr_in,
	input  wire [1:0]  wb_sel_in,
	input  wire [15:0] wb_dat_in,
	output reg  [15:0] wb_dat_out,
	output reg         wb_ack_out,
	output reg         serial_data_out_pin_out,
	output reg         serial_data_out_pin_oe_out,
	output reg         transmit_clock_pin_out,
	output reg         transmit_clock_pin_oe_out,
	input  wire        transmit_clock_pin_in,
	output reg         receive_clock_pin_out,
	output reg         receive_clock_pin_oe_out,
	input  wire        receive_clock_pin_in,
	input  wire        serial_data_in_pin_in,
	output reg         tx_empty_signal_out,
	output reg         rx_full_signal_out,
	output reg         serial_unit_irq_out
);

	reg  [15:0] tbuf_reg;
	reg  [15:0] tshift_reg;
	reg  [3:0]  tcnt_reg;
	reg         tbusy_reg;
	reg         tx_buffer_empty_flag_reg;
	reg         tue_reg;
	reg         tslave_hold_reg;
	reg  [15:0] rbuf_reg;
	reg  [15:0] rshift_reg;
	reg  [3:0]  rcnt_reg;
	reg         rbusy_reg;
	reg         rx_buffer_full_flag_reg;
	reg         roe_reg;
	reg  [7:0]  con1_reg;
	reg  [7:0]  con2_reg;
	reg  [7:0]  baud_reg;
	reg  [8:0]  prs_reg;
	reg  [7:0]  pin_function_select_reg;
	reg  [7:0]  serial_clock_source_config_reg;
	reg  [2:0]  txc_sync_reg;
	reg  [2:0]  rxc_sync_reg;
	reg  [15:0] rd_next;

	wire [6:0]  bg_count;
	wire        bg_clk;
	wire        bg_rise;
	wire        bg_fall;
	wire        wb_req;
	wire        wr;
	wire        rd;
	wire        tbuf_wr;
	wire        rbuf_rd;
	wire        con1_wr;
	wire        tx_master;
	wire        rx_master;
	wire        auto_mode;
	wire        tx_en;
	wire        rx_en;
	wire        tx_rise;
	wire        tx_fall;
	wire        rx_rise;
	wire        tx_load;
	wire        tx_word_done;
	wire        rx_word_done;

	sstu_baud_gen u_baud (
		.ref_clk_in     (ref_clk_in),
		.srst_in        (srst_in),
		.enable_in      (baud_reg[`SSTU_BAUD_EN]),
		.reload_in      (baud_reg[`SSTU_BAUD_BV_HI:0]),
		.reload_load_in (wr && wb_adr_in == `SSTU_BAUD_ADDR),
		.src_serclk_in  (serial_clock_source_config_reg[`SSTU_SERIAL_CLOCK_SOURCE_CONFIG_SRC]),
		.prescale_in    (prs_reg),
		.count_out      (bg_count),
		.baud_out       (bg_clk),
		.rise_out       (bg_rise),
		.fall_out       (bg_fall)
	);

	assign wb_req    = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign wr        = wb_req & wb_we_in;
	assign rd        = wb_req & ~wb_we_in;
	assign tbuf_wr   = wr && wb_adr_in == `SSTU_TBUF_ADDR;
	assign rbuf_rd   = rd && wb_adr_in == `SSTU_RBUF_ADDR;
	assign con1_wr   = wr && wb_adr_in == `SSTU_CON1_ADDR && wb_sel_in[0];
	assign tx_master = con2_reg[`SSTU_C2_TX_MASTER_SELECT]; // (R23)
	assign rx_master = con2_reg[`SSTU_C2_RX_MASTER_SELECT]; // (R23)
	assign auto_mode = con2_reg[`SSTU_C2_AUTO] & tx_master;
	assign tx_en     = con1_reg[`SSTU_C1_TEN];
	assign rx_en     = con1_reg[`SSTU_C1_REN];

	// edge detect reads only the second and third synchroniser stages
	assign tx_rise = tx_master ? bg_rise : (txc_sync_reg[1] & ~txc_sync_reg[2]); // (R2) (R24)
	assign tx_fall = tx_master ? bg_fall : (~txc_sync_reg[1] & txc_sync_reg[2]); // (R2) (R24)
	assign rx_rise = rx_master ? bg_rise : (rxc_sync_reg[1] & ~rxc_sync_reg[2]); // (R20) (R24)

	// word start: enable with idle shifter, or autotransmit with full buffer
	assign tx_load      = !tbusy_reg && (auto_mode ? !tx_buffer_empty_flag_reg : tx_en); // (R1) (R11)
	assign tx_word_done = tbusy_reg && tx_fall && !tslave_hold_reg
		&& tcnt_reg == `SSTU_BIT_CNT_LAST;
	assign rx_word_done = rbusy_reg && rx_rise && rcnt_reg == `SSTU_BIT_CNT_LAST;

	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			txc_sync_reg <= 3'h7;
			rxc_sync_reg <= 3'h7;
		end else begin
			txc_sync_reg <= {txc_sync_reg[1:0], transmit_clock_pin_in}; // (R24)
			rxc_sync_reg <= {rxc_sync_reg[1:0], receive_clock_pin_in}; // (R24)
		end
	end

	// register file
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			con1_reg   <= `SSTU_CON1_RST;
			con2_reg   <= `SSTU_CON2_RST;
			baud_reg   <= `SSTU_BAUD_RST;
			prs_reg    <= `SSTU_PRS_RST;
			pin_function_select_reg <= `SSTU_PIN_FUNCTION_SELECT_RST;
			serial_clock_source_config_reg <= `SSTU_SERIAL_CLOCK_SOURCE_CONFIG_RST;
			tbuf_reg   <= 16'h0000;
		end else if (wr) begin
			case (wb_adr_in)
			`SSTU_TBUF_ADDR: begin
				if (wb_sel_in[0])
					tbuf_reg[7:0] <= wb_dat_in[7:0];
				if (wb_sel_in[1])
					tbuf_reg[15:8] <= wb_dat_in[15:8];
			end
			`SSTU_BAUD_ADDR: begin
				if (wb_sel_in[0])
					baud_reg <= wb_dat_in[7:0];
			end
			`SSTU_CON1_ADDR: begin
				if (wb_sel_in[0]) begin
					con1_reg[`SSTU_C1_TIE] <= wb_dat_in[`SSTU_C1_TIE];
					con1_reg[`SSTU_C1_TEN] <= wb_dat_in[`SSTU_C1_TEN];
					con1_reg[`SSTU_C1_RIE] <= wb_dat_in[`SSTU_C1_RIE];
					con1_reg[`SSTU_C1_REN] <= wb_dat_in[`SSTU_C1_REN];
				end
			end
			`SSTU_CON2_ADDR: begin
				if (wb_sel_in[0])
					con2_reg <= {5'h00, wb_dat_in[2:0]};
			end
			`SSTU_PRS_ADDR: begin
				if (wb_sel_in[0])
					prs_reg[7:0] <= wb_dat_in[7:0];
				if (wb_sel_in[1])
					prs_reg[8] <= wb_dat_in[8];
			end
			`SSTU_PIN_FUNCTION_SELECT_ADDR: begin
				if (wb_sel_in[0])
					pin_function_select_reg <= wb_dat_in[7:0];
			end
			`SSTU_SERIAL_CLOCK_SOURCE_CONFIG_ADDR: begin
				if (wb_sel_in[0])
					serial_clock_source_config_reg <= wb_dat_in[7:0];
			end
			default: begin
			end
			endcase
		end
	end

	// transmitter
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			tshift_reg      <= 16'h0000;
			tcnt_reg        <= 4'h0;
			tbusy_reg       <= 1'b0;
			tx_buffer_empty_flag_reg        <= 1'b1; // (R4)
			tue_reg         <= 1'b0;
			tslave_hold_reg <= 1'b0;
		end else begin
			if (tx_load) begin
				tshift_reg      <= tbuf_reg; // (R1)
				tcnt_reg        <= 4'h0;
				tbusy_reg       <= 1'b1;
				tslave_hold_reg <= !tx_master; // (R13)
			end else if (tbusy_reg && tx_fall) begin
				if (tslave_hold_reg) begin
					tslave_hold_reg <= 1'b0; // (R13)
				end else if (tcnt_reg != `SSTU_BIT_CNT_LAST) begin
					tshift_reg <= {tshift_reg[14:0], 1'b0}; // (R1)
					tcnt_reg   <= tcnt_reg + 4'h1;
				end else if (!auto_mode && tx_en) begin
					tshift_reg <= tbuf_reg; // (R5) (R6) (R9)
					tcnt_reg   <= 4'h0;
				end else if (auto_mode && !tx_buffer_empty_flag_reg) begin
					tshift_reg <= tbuf_reg; // (R11)
					tcnt_reg   <= 4'h0;
				end else begin
					tbusy_reg <= 1'b0; // (R8) (R11)
				end
			end
			// set from a transfer wins over clear from a write
			if (tx_load || (tx_word_done && (auto_mode ? !tx_buffer_empty_flag_reg : tx_en)))
				tx_buffer_empty_flag_reg <= 1'b1; // (R4)
			else if (tbuf_wr)
				tx_buffer_empty_flag_reg <= 1'b0; // (R4)
			if (tx_word_done && !auto_mode && tx_en && tx_buffer_empty_flag_reg)
				tue_reg <= 1'b1; // (R6) (R12)
			else if (con1_wr && !wb_dat_in[`SSTU_C1_TUE])
				tue_reg <= 1'b0;
		end
	end

	// receiver
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			rshift_reg <= 16'h0000;
			rbuf_reg   <= 16'h0000;
			rcnt_reg   <= 4'h0;
			rbusy_reg  <= 1'b0;
			rx_buffer_full_flag_reg   <= 1'b0; // (R15)
			roe_reg    <= 1'b0;
		end else begin
			if (rx_rise && (rbusy_reg || rx_en)) begin
				rshift_reg <= {rshift_reg[14:0], serial_data_in_pin_in}; // (R14) (R20)
				rcnt_reg   <= rcnt_reg + 4'h1;
				rbusy_reg  <= !(rx_word_done && !rx_en); // (R18) (R19)
			end
			if (rx_word_done)
				rbuf_reg <= {rshift_reg[14:0], serial_data_in_pin_in}; // (R14) (R16)
			if (rx_word_done)
				rx_buffer_full_flag_reg <= 1'b1; // (R15)
			else if (rbuf_rd)
				rx_buffer_full_flag_reg <= 1'b0; // (R15)
			if (rx_word_done && rx_buffer_full_flag_reg && !rbuf_rd)
				roe_reg <= 1'b1; // (R16)
			else if (con1_wr && !wb_dat_in[`SSTU_C1_ROE])
				roe_reg <= 1'b0;
		end
	end

	// read multiplexer
	always @* begin
		case (wb_adr_in)
		`SSTU_TBUF_ADDR:   rd_next = tbuf_reg;
		`SSTU_RBUF_ADDR:   rd_next = rbuf_reg;
		`SSTU_BAUD_ADDR:   rd_next = {8'h00, baud_reg};
		`SSTU_CON1_ADDR:   rd_next = {8'h00, tue_reg, tx_buffer_empty_flag_reg, con1_reg[5:4],
			roe_reg, rx_buffer_full_flag_reg, con1_reg[1:0]};
		`SSTU_CON2_ADDR:   rd_next = {8'h00, con2_reg};
		`SSTU_CTR_ADDR:    rd_next = {8'h00, baud_reg[`SSTU_BAUD_EN], bg_count};
		`SSTU_PRS_ADDR:    rd_next = {7'h00, prs_reg};
		`SSTU_PIN_FUNCTION_SELECT_ADDR: rd_next = {8'h00, pin_function_select_reg};
		`SSTU_SERIAL_CLOCK_SOURCE_CONFIG_ADDR: rd_next = {8'h00, serial_clock_source_config_reg};
		default:           rd_next = 16'h0000;
		endcase
	end

	// bus answer and pin drivers
	always @(posedge ref_clk_in) begin
		if (srst_in) begin
			wb_ack_out                 <= 1'b0;
			wb_dat_out                 <= 16'h0000;
			serial_data_out_pin_out    <= 1'b0;
			serial_data_out_pin_oe_out <= 1'b0;
			transmit_clock_pin_out     <= 1'b0;
			transmit_clock_pin_oe_out  <= 1'b0;
			receive_clock_pin_out      <= 1'b0;
			receive_clock_pin_oe_out   <= 1'b0;
			tx_empty_signal_out        <= 1'b1;
			rx_full_signal_out         <= 1'b0;
			serial_unit_irq_out        <= 1'b0;
		end else begin
			wb_ack_out                 <= wb_req;
			wb_dat_out                 <= rd ? rd_next : 16'h0000;
			serial_data_out_pin_out    <= tshift_reg[15]; // (R1) (R13)
			serial_data_out_pin_oe_out <= tbusy_reg; // (R8)
			transmit_clock_pin_out     <= bg_clk;
			transmit_clock_pin_oe_out  <= tbusy_reg & tx_master; // (R8)
			receive_clock_pin_out      <= bg_clk;
			receive_clock_pin_oe_out   <= rx_master & (rbusy_reg | rx_en); // (R18)
			tx_empty_signal_out        <= tx_buffer_empty_flag_reg; // (R7)
			rx_full_signal_out         <= rx_buffer_full_flag_reg; // (R17)
			serial_unit_irq_out        <= (rx_buffer_full_flag_reg & con1_reg[`SSTU_C1_RIE])
				| (tx_buffer_empty_flag_reg & con1_reg[`SSTU_C1_TIE]); // (R17)
		end
	end

endmodule

`default_nettype wire

// ---- sim/sstu_props.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sstu_map.vh"
module sstu_props (
	input wire logic        ref_clk_in,
	input wire logic        srst_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [15:0] wb_adr_in,
	input wire logic [15:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        serial_data_out_pin_out,
	input wire logic        serial_data_out_pin_oe_out,
	input wire logic        transmit_clock_pin_out,
	input wire logic        transmit_clock_pin_oe_out,
	input wire logic        tx_empty_signal_out,
	input wire logic        rx_full_signal_out,
	input wire logic        serial_unit_irq_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);
	sequence take_s;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence rd_s;
		wb_ack_out && !$past(wb_we_in);
	endsequence
	sequence tbuf_wr_s;
		wb_ack_out && $past(wb_we_in) && $past(wb_adr_in) == `SSTU_TBUF_ADDR;
	endsequence
	ack_take_a: assert property (take_s |=> wb_ack_out)
		else $error("no ack");
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	wr_zero_a: assert property (wb_ack_out && $past(wb_we_in) |-> wb_dat_out == 16'h0000)
		else $error("write data not zero");
	unmap_zero_a: assert property (rd_s ##0 $past(wb_adr_in) == 16'hF48C |-> !wb_dat_out)
		else $error("unmapped read not zero");
	tbe_clear_a: assert property (tbuf_wr_s |-> ##[0:2] !tx_empty_signal_out)
		else $error("empty flag kept");
	rbf_clear_a: assert property (rd_s ##0 $past(wb_adr_in) == `SSTU_RBUF_ADDR
		|-> ##[0:2] !rx_full_signal_out)
		else $error("full flag kept");
	irq_quiet_a: assert property ((!tx_empty_signal_out && !rx_full_signal_out)[*2]
		|-> !serial_unit_irq_out)
		else $error("irq without source");
	txd_edge_a: assert property (serial_data_out_pin_oe_out && $past(serial_data_out_pin_oe_out)
		&& transmit_clock_pin_oe_out && $changed(serial_data_out_pin_out)
		|-> $past(transmit_clock_pin_out, 2) && !$past(transmit_clock_pin_out))
		else $error("data moved off clock fall");
	oe_pair_a: assert property (transmit_clock_pin_oe_out |-> serial_data_out_pin_oe_out)
		else $error("clock driven without data");
endmodule
bind sstu_unit sstu_props sstu_props_i (.*);
`default_nettype wire

// ---- sim/sstu_peer.sv ----
`timescale 1ns/1ns
`default_nettype none
// external clock master feeding the receiver, idle high between frames
module sstu_peer (
	input  wire logic ref_clk_in,
	output var logic  clk_out,
	output var logic  dat_out
);
	initial begin
		clk_out = 1'b1;
		dat_out = 1'b1;
	end
	// clock only runs inside send, called with the receiver enabled except for the last call, made after it is disabled
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			repeat (8) @(posedge ref_clk_in);
			clk_out <= 1'b0;
			dat_out <= w[i];
			repeat (8) @(posedge ref_clk_in);
			clk_out <= 1'b1;
		end
		repeat (8) @(posedge ref_clk_in);
		dat_out <= ~w[0];
	endtask
endmodule
`default_nettype wire

// ---- sim/sstu_unit_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sstu_map.vh"
module sstu_unit_tb;
	logic        ref_clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        wb_cyc_in = 1'b0;
	logic        wb_stb_in = 1'b0;
	logic        wb_we_in = 1'b0;
	logic [15:0] wb_adr_in = 16'h0000;
	logic [1:0]  wb_sel_in = 2'h3;
	logic [15:0] wb_dat_in = 16'h0000;
	logic        transmit_clock_pin_in = 1'b1;
	logic        receive_clock_pin_in;
	logic        serial_data_in_pin_in;
	logic [15:0] wb_dat_out;
	logic        wb_ack_out;
	logic        serial_data_out_pin_out;
	logic        serial_data_out_pin_oe_out;
	logic        transmit_clock_pin_out;
	logic        transmit_clock_pin_oe_out;
	logic        receive_clock_pin_out;
	logic        receive_clock_pin_oe_out;
	logic        tx_empty_signal_out;
	logic        rx_full_signal_out;
	logic        serial_unit_irq_out;
	logic [15:0] rd;
	logic [15:0] w;
	logic        pc;
	logic        pd;
	logic        po;
	logic        bits[$];
	int          err_total = 0;
	int          check_count = 0;
	sstu_unit sstu_unit_i (.*);
	sstu_peer sstu_peer_i (
		.ref_clk_in(ref_clk_in),
		.clk_out   (receive_clock_pin_in),
		.dat_out   (serial_data_in_pin_in)
	);
	always #5 ref_clk_in = ~ref_clk_in;
	// collect the bit shown just before each falling transmit clock
	always @(posedge ref_clk_in) begin
		if (pc && po && !transmit_clock_pin_out)
			bits.push_back(pd);
		pc <= transmit_clock_pin_out;
		pd <= serial_data_out_pin_out;
		po <= serial_data_out_pin_oe_out;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %0t saw %h want %h", $time, s, e);
		end
	endtask
	function automatic logic [15:0] fill_word(input logic b);
		return {16{b}};
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 2000) begin
			err_total++;
			$display("FAIL %0t timeout", $time);
			report_and_stop();
		end
	endtask
	task automatic wb(input logic wr, input logic [15:0] a, input logic [15:0] d);
		int n;
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= wr;
		wb_adr_in <= a;
		wb_dat_in <= d;
		n = 0;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 2000);
		tmo(n);
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic wait_for(ref logic s, input logic v);
		int n;
		for (n = 0; s !== v && n < 2000; n++)
			@(posedge ref_clk_in);
		tmo(n);
		@(posedge ref_clk_in);
	endtask
	task automatic get_word(output logic [15:0] g);
		int n;
		for (n = 0; bits.size() < 16 && n < 2000; n++)
			@(posedge ref_clk_in);
		tmo(n);
		for (int i = 0; i < 16; i++)
			g = {g[14:0], bits.pop_front()};
	endtask
	initial begin
		w = 16'($urandom(32'hC836));
		repeat (8) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		@(posedge ref_clk_in);
		wb(0, `SSTU_CON1_ADDR, 16'h0000);
		chk(rd, 16'h0040);
		chk(16'(rx_full_signal_out), 16'h0000);
		wb(1, 16'hF48C, 16'hFFFF);
		wb(0, 16'hF48C, 16'h0000);
		chk(rd, 16'h0000);
		wb(1, `SSTU_SERIAL_CLOCK_SOURCE_CONFIG_ADDR, 16'h0004);
		wb(1, `SSTU_BAUD_ADDR, 16'h0081);
		wb(1, `SSTU_TBUF_ADDR, w);
		wb(1, `SSTU_CON2_ADDR, 16'h0002);
		wb(1, `SSTU_CON1_ADDR, 16'h0010);
		get_word(rd);
		chk(rd, w);
		chk(16'(tx_empty_signal_out), 16'h0001);
		wb(0, `SSTU_CON1_ADDR, 16'h0000);
		chk(rd & 16'h0080, 16'h0080);
		wb(1, `SSTU_TBUF_ADDR, ~w);
		get_word(rd);
		chk(rd, w);
		get_word(rd);
		chk(rd, ~w);
		wb(1, `SSTU_CON1_ADDR, 16'h0000);
		get_word(rd);
		chk(rd, ~w);
		wait_for(serial_data_out_pin_oe_out, 1'b0);
		repeat (300) @(posedge ref_clk_in);
		chk(16'(bits.size()), 16'h0000);
		wb(1, `SSTU_CON2_ADDR, 16'h0006);
		wb(1, `SSTU_CON1_ADDR, 16'h0010);
		w = 16'($urandom());
		wb(1, `SSTU_TBUF_ADDR, w);
		get_word(rd);
		chk(rd, w);
		wait_for(serial_data_out_pin_oe_out, 1'b0);
		wb(0, `SSTU_CON1_ADDR, 16'h0000);
		chk(rd & 16'h00D0, 16'h0050);
		wb(1, `SSTU_CON1_ADDR, 16'h0003);
		wb(1, `SSTU_CON2_ADDR, 16'h0000);
		w = 16'($urandom());
		sstu_peer_i.send(w);
		wait_for(rx_full_signal_out, 1'b1);
		chk(16'(serial_unit_irq_out), 16'h0001);
		wb(0, `SSTU_RBUF_ADDR, 16'h0000);
		chk(rd, w);
		repeat (2) @(posedge ref_clk_in);
		chk(16'(rx_full_signal_out), 16'h0000);
		chk(16'(serial_unit_irq_out), 16'h0000);
		sstu_peer_i.send(16'($urandom()));
		w = 16'($urandom());
		sstu_peer_i.send(w);
		repeat (20) @(posedge ref_clk_in);
		wb(0, `SSTU_CON1_ADDR, 16'h0000);
		chk(rd & 16'h000C, 16'h000C);
		wb(0, `SSTU_RBUF_ADDR, 16'h0000);
		chk(rd, w);
		// receiver disabled mid-word still finishes and loads that word
		w = 16'($urandom());
		fork
			sstu_peer_i.send(w);
			begin
				repeat (40) @(posedge ref_clk_in);
				wb(1, `SSTU_CON1_ADDR, 16'h0000);
			end
		join
		repeat (8) @(posedge ref_clk_in);
		chk(16'(rx_full_signal_out), 16'h0001);
		wb(0, `SSTU_RBUF_ADDR, 16'h0000);
		chk(rd, w);
		sstu_peer_i.send(16'($urandom()));
		repeat (8) @(posedge ref_clk_in);
		chk(16'(rx_full_signal_out), 16'h0000);
		// receiver in master mode drives its clock pin while busy
		wb(1, `SSTU_CON2_ADDR, 16'h0001);
		wb(1, `SSTU_CON1_ADDR, 16'h0001);
		repeat (20) @(posedge ref_clk_in);
		chk(16'(receive_clock_pin_oe_out), 16'h0001);
		wb(1, `SSTU_CON1_ADDR, 16'h0000);
		wait_for(receive_clock_pin_oe_out, 1'b0);
		chk(16'(rx_full_signal_out), 16'h0001);
		wb(0, `SSTU_RBUF_ADDR, 16'h0000);
		chk(rd, fill_word(serial_data_in_pin_in));
		// transmitter in slave mode, clocked from its clock pin
		wb(1, `SSTU_CON2_ADDR, 16'h0000);
		w = 16'($urandom());
		wb(1, `SSTU_TBUF_ADDR, w);
		wb(1, `SSTU_CON1_ADDR, 16'h0010);
		repeat (4) @(posedge ref_clk_in);
		chk(16'(serial_data_out_pin_out), 16'(w[15]));
		wb(1, `SSTU_CON1_ADDR, 16'h0000);
		for (int i = 0; i < 17; i++) begin
			transmit_clock_pin_in <= 1'b0;
			repeat (8) @(posedge ref_clk_in);
			if (i < 16)
				chk(16'(serial_data_out_pin_out), 16'(w[15 - i]));
			transmit_clock_pin_in <= 1'b1;
			repeat (8) @(posedge ref_clk_in);
		end
		chk(16'(serial_data_out_pin_oe_out), 16'h0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
